// [interrupt_driven_micro_dma_tb_top.sv]
// Purpose: Self-checking bench for umd_engine
// Assumes: Inputs change on the falling edge
// Notes:   Interrupt and soft starts, burst, modes
`timescale 1ns/10ps
module interrupt_driven_micro_dma_tb_top;
  localparam logic [8:0] SWR = umd_pkg::SW_REQ_OFFSET;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   cpu_halted = 1'b0;
  logic                   hold = 1'b0;
  logic [32:0]            raise = 33'h0;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [8:0]             reg_addr = 9'h0;
  logic [7:0]             reg_wdata = 8'h0;
  umd_pkg::umd_param_wr_t pwr = '0;
  logic                   dma_req, dma_ack;
  logic [7:0]             reg_rdata, tc_irq, tc_v;
  logic [2:0]             dma_level;
  logic [32:0]            int_pend, int_clr, dma_owned, clr_v;
  logic [31:0]            mem_rdata, wr_d, got;
  logic [5:0]             state_out;
  logic [23:0]            wr_a, rd_a;
  logic [1:0]             wr_s;
  umd_pkg::umd_bus_req_t  bus_q;
  int                     err_count = 0, compares = 0, wr_n = 0, tc_n = 0, base;

  always #2.5 clk = ~clk;

  umd_engine umd_engine_i (.clk, .rst, .int_pend, .cpu_halted, .dma_ack, .pwr, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .mem_rdata, .reg_rdata, .dma_req, .dma_level, .int_clr, .dma_owned, .tc_irq, .bus_q, .state_out);
  umd_cpu_model umd_cpu_model_i (.clk, .rst, .hold, .raise, .dma_req, .int_clr, .dma_owned, .bus_q, .dma_ack,
    .int_pend, .mem_rdata);

  always @(posedge clk) begin
    if (bus_q.valid && bus_q.write) begin
      wr_n++;
      wr_a = bus_q.addr;
      wr_d = bus_q.wdata;
      wr_s = bus_q.size;
    end
    if (bus_q.valid && !bus_q.write) rd_a = bus_q.addr;
    if (tc_irq != 8'h0) begin
      tc_n++;
      tc_v = tc_irq;
    end
    if (int_clr != 33'h0) clr_v = int_clr;
  end

  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic reg_read(input logic [8:0] a, output logic [31:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    d = {24'h0, reg_rdata};
  endtask
  task automatic param(input logic [2:0] c, input logic [2:0] s, input logic [31:0] d);
    @(negedge clk);
    pwr = '{1'b1, c, s, d};
    @(negedge clk);
    pwr.wr = 1'b0;
  endtask
  task automatic arm(input logic [2:0] c, input logic [7:0] v, input logic [23:0] s, input logic [23:0] d,
                     input logic [15:0] n, input logic [4:0] m);
    param(c, umd_pkg::PARAM_SRC, {8'h0, s});
    param(c, umd_pkg::PARAM_DST, {8'h0, d});
    param(c, umd_pkg::PARAM_CNT, {16'h0, n});
    param(c, umd_pkg::PARAM_MODE, {27'h0, m});
    param(c, umd_pkg::PARAM_VEC, {24'h0, v});
  endtask
  task automatic kick(input logic [32:0] r);
    @(negedge clk);
    raise = r;
    @(negedge clk);
    raise = 33'h0;
  endtask
  task automatic wait_wr(input int n);
    int i;
    i = 0;
    while (wr_n < n && i < 300) begin
      @(negedge clk);
      i++;
    end
    repeat (4) @(negedge clk);
    while (state_out !== 6'h01 && i < 300) begin
      @(negedge clk);
      i++;
    end
    check("wait done", i < 300, 1'b1);
  endtask
  task automatic report_and_stop;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop;
  end

  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check("level", dma_level, 3'h6);
    check("req idle", dma_req, 1'b0);
    reg_read(SWR, got);
    check("swr reset", got, umd_pkg::SW_REQ_RESET);
    reg_write(9'h100, 8'hff);
    reg_read(9'h100, got);
    check("unmapped", got, 8'h00);
    arm(3'h2, 8'h05, 24'h100, 24'h200, 16'h2, {umd_pkg::MODE_DST_INC, umd_pkg::SIZE_4});
    kick(33'h10);
    wait_wr(1);
    check("clr", clr_v, 33'h10);
    check("dst", wr_a, 24'h200);
    check("data", wr_d, {8'h5a, 24'h100});
    check("size4", wr_s, umd_pkg::SIZE_4);
    check("armed", dma_owned[4], 1'b1);
    kick(33'h10);
    wait_wr(2);
    repeat (2) @(negedge clk);
    check("tc", tc_v, 8'h04);
    check("disarmed", dma_owned[4], 1'b0);
    kick(33'h10);
    repeat (20) @(negedge clk);
    check("ordinary", wr_n, 2);
    arm(3'h0, 8'h01, 24'h300, 24'h400, 16'h1, {umd_pkg::MODE_DST_INC, umd_pkg::SIZE_2});
    arm(3'h7, 8'h02, 24'h500, 24'h600, 16'h1, {umd_pkg::MODE_DST_INC, umd_pkg::SIZE_2});
    hold = 1'b1;
    kick(33'h3);
    repeat (4) @(negedge clk);
    hold = 1'b0;
    wait_wr(3);
    check("first", wr_a, 24'h400);
    check("size2", wr_s, umd_pkg::SIZE_2);
    wait_wr(4);
    check("second", wr_a, 24'h600);
    arm(3'h3, umd_pkg::VEC_NONE, 24'h700, 24'h800, 16'h3, 5'h0);
    cpu_halted = 1'b1;
    reg_write(SWR, 8'h08);
    repeat (20) @(negedge clk);
    reg_read(SWR, got);
    check("pending", got, 8'h08);
    check("halted", wr_n, 4);
    check("req held", dma_req, 1'b1);
    cpu_halted = 1'b0;
    wait_wr(5);
    reg_read(SWR, got);
    check("self clear", got, 8'h00);
    check("soft data", wr_d, {8'h5a, 24'h700});
    check("soft tc", tc_n, 3);
    reg_write(SWR, 8'h00);
    repeat (10) @(negedge clk);
    check("zero write", wr_n, 5);
    reg_write(umd_pkg::BURST_SEL_OFFSET, 8'h02);
    reg_read(umd_pkg::BURST_SEL_OFFSET, got);
    check("burst reg", got, 8'h02);
    arm(3'h1, 8'h07, 24'h900, 24'ha00, 16'h3, 5'h0);
    kick(33'h40);
    wait_wr(8);
    repeat (2) @(negedge clk);
    check("burst tc", tc_v, 8'h02);
    check("burst n", tc_n, 4);
    for (int m = 0; m < 7; m++) begin
      arm(3'h4, umd_pkg::VEC_NONE, 24'h1000, 24'h2000, 16'h5, {m[2:0], umd_pkg::SIZE_1});
      repeat (2) begin
        reg_write(SWR, 8'h10);
        wait_wr(wr_n + 1);
      end
      check("mode src", rd_a, 24'h1000 + (m == 2 || m == 4) - (m == 3 || m == 5));
      check("mode dst", wr_a, 24'h2000 + (m == 0 || m == 4) - (m == 1 || m == 5));
    end
    base = wr_n;
    arm(3'h4, umd_pkg::VEC_NONE, 24'h1000, 24'h2000, 16'h5, {umd_pkg::MODE_COUNTER, umd_pkg::SIZE_1});
    repeat (2) begin
      reg_write(SWR, 8'h10);
      wait_wr(base);
    end
    check("counter bus", wr_n, base);
    param(3'h4, umd_pkg::PARAM_MODE, {27'h0, umd_pkg::MODE_DST_INC, umd_pkg::SIZE_1});
    reg_write(SWR, 8'h10);
    wait_wr(base + 1);
    check("counter src", rd_a, 24'h1002);
    arm(3'h2, 8'h05, 24'h100, 24'h200, 16'h2, 5'h0);
    base = wr_n;
    kick(33'h10);
    wait (state_out != 6'h01);
    reg_write(SWR, 8'h04);
    wait_wr(base + 1);
    repeat (10) @(negedge clk);
    reg_read(SWR, got);
    check("soft dropped", got, 8'h00);
    check("one transfer", wr_n, base + 1);
    report_and_stop;
  end
endmodule // interrupt_driven_micro_dma_tb_top

bind umd_engine umd_engine_asserts umd_engine_asserts_i (.clk, .rst, .cpu_halted, .reg_rd, .mem_rdata, .reg_rdata,
  .dma_level, .int_clr, .tc_irq, .bus_q, .state_out);

// [umd_channel.sv]
// Purpose: One micro DMA channel parameter set and its update logic
// Assumes: Parameters loaded through the dedicated parameter port pwr
// Notes:   Address update follows the mode, counter wraps from zero
`timescale 1ns/10ps
module umd_channel (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire umd_pkg::umd_param_wr_t pwr,
  input  wire logic [2:0]           ch_id,
  input  wire logic                 step,
  input  wire logic                 clr_vec,
  output logic [23:0]               src_q,
  output logic [23:0]               dst_q,
  output logic [15:0]               cnt_q,
  output logic [4:0]                mode_q,
  output logic [7:0]                vec_q
);

  logic        sel_me;
  logic [23:0] stride;
  logic [2:0]  amode;

  assign sel_me = pwr.wr && (pwr.ch == ch_id);
  assign amode  = mode_q[4:2];

  always_comb begin
    case (mode_q[1:0])
      umd_pkg::SIZE_2: stride = 24'h000002;
      umd_pkg::SIZE_4: stride = 24'h000004;
      default:         stride = 24'h000001;
    endcase
    if (amode == umd_pkg::MODE_COUNTER) begin
      stride = 24'h000001;
    end
  end

  // Only low 24 address bits are kept
  always_ff @(posedge clk) begin
    if (rst) begin
      src_q <= 24'h000000;
    end else if (sel_me && pwr.sel == umd_pkg::PARAM_SRC) begin
      src_q <= pwr.data[23:0];
    end else if (step) begin
      case (amode)
        umd_pkg::MODE_SRC_INC, umd_pkg::MODE_BOTH_INC, umd_pkg::MODE_COUNTER: src_q <= src_q + stride;
        umd_pkg::MODE_SRC_DEC, umd_pkg::MODE_BOTH_DEC: src_q <= src_q - stride;
        default: src_q <= src_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dst_q <= 24'h000000;
    end else if (sel_me && pwr.sel == umd_pkg::PARAM_DST) begin
      dst_q <= pwr.data[23:0];
    end else if (step) begin
      case (amode)
        umd_pkg::MODE_DST_INC, umd_pkg::MODE_BOTH_INC: dst_q <= dst_q + stride;
        umd_pkg::MODE_DST_DEC, umd_pkg::MODE_BOTH_DEC: dst_q <= dst_q - stride;
        default: dst_q <= dst_q;
      endcase
    end
  end

  // Zero start value wraps, giving 65536 transfers
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else if (sel_me && pwr.sel == umd_pkg::PARAM_CNT) begin
      cnt_q <= pwr.data[15:0];
    end else if (step) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= 5'h00;
    end else if (sel_me && pwr.sel == umd_pkg::PARAM_MODE) begin
      mode_q <= pwr.data[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vec_q <= umd_pkg::VEC_NONE;
    end else if (clr_vec) begin
      vec_q <= umd_pkg::VEC_NONE;
    end else if (sel_me && pwr.sel == umd_pkg::PARAM_VEC) begin
      vec_q <= pwr.data[7:0];
    end
  end

endmodule // umd_channel

// [umd_cpu_model.sv]
// Purpose: CPU, memory and interrupt flag model
// Assumes: Acks one cycle after a request unless held
// Notes:   Disarmed flags go to ordinary service
`timescale 1ns/10ps
module umd_cpu_model (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  hold,
  input  wire logic [32:0]           raise,
  input  wire logic                  dma_req,
  input  wire logic [32:0]           int_clr,
  input  wire logic [32:0]           dma_owned,
  input  wire umd_pkg::umd_bus_req_t bus_q,
  output logic                       dma_ack,
  output logic [32:0]                int_pend,
  output logic [31:0]                mem_rdata
);
  always_ff @(posedge clk) begin
    if (rst) begin
      dma_ack  <= 1'b0;
      int_pend <= 33'h0;
    end else begin
      dma_ack  <= dma_req && !hold;
      int_pend <= (int_pend & ~int_clr & dma_owned) | raise;
    end
  end
  // Idle bus shows a pattern that moves with the address
  assign mem_rdata = (bus_q.valid && !bus_q.write) ? {8'h5a, bus_q.addr} : {8'ha5, ~bus_q.addr};
endmodule // umd_cpu_model

// [umd_engine.sv]
// Purpose: Eight channel interrupt triggered micro DMA engine
// Assumes: CPU grants bus cycles through ack; memory answers in one cycle
// Notes:   Channel parameters loaded through the dedicated parameter port
//
// Behaviour
// - DMA requests presented at level six
// - No service while halted; requests stay pending
// - Eight independent channels
// - Accepted request clears source interrupt flag
// - Move block, decrement counter, update addresses
// - Nonzero counter keeps start vector armed
// - Zero counter raises end interrupt, disarms
// - Lowest channel number wins arbitration
// - Disarmed source becomes ordinary interrupt
// - Addresses hold only 24 bits
// - Counter 16 bits, zero means 65536
// - 33 interrupt sources plus software start
// - Five states: fetch, fetch, read, write, fetch; engine walks fetch, read, write, tail, done
// - Writing one starts one transfer
// - Software request bit self clears on completion
// - Busy request bit reads one
// - Burst channels repeat until counter zero
// - Soft start during interrupt transfer keeps counter
// - Low mode bits select block size
// - Upper mode bits select address behaviour
`timescale 1ns/10ps
module umd_engine (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [32:0]            int_pend,
  input  wire logic                   cpu_halted,
  input  wire logic                   dma_ack,
  input  wire umd_pkg::umd_param_wr_t pwr,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [8:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic [31:0]            mem_rdata,
  output logic [7:0]                  reg_rdata,
  output logic                        dma_req,
  output logic [2:0]                  dma_level,
  output logic [32:0]                 int_clr,
  output logic [32:0]                 dma_owned,
  output logic [7:0]                  tc_irq,
  output umd_pkg::umd_bus_req_t       bus_q,
  output logic [5:0]                  state_out
);

  umd_pkg::umd_state_t state_q;
  umd_pkg::umd_state_t state_d;

  logic [7:0]  sw_req_q;
  logic [7:0]  burst_q;
  logic [7:0]  ch_req;
  logic [7:0]  step;
  logic [7:0]  clr_vec;
  logic [2:0]  act_q;
  logic        act_sw_q;
  logic [7:0]  sw_keep;
  logic        any_req;
  logic [2:0]  win;
  logic [32:0] owned;
  logic        end_hit;
  logic [7:0]  sw_set;

  logic [23:0] src   [umd_pkg::NUM_CH];
  logic [23:0] dst   [umd_pkg::NUM_CH];
  logic [15:0] cnt   [umd_pkg::NUM_CH];
  logic [4:0]  mode  [umd_pkg::NUM_CH];
  logic [7:0]  vec   [umd_pkg::NUM_CH];

  genvar g;
  generate
    for (g = 0; g < umd_pkg::NUM_CH; g++) begin : g_ch
      umd_channel u_ch (
        .clk     (clk),
        .rst     (rst),
        .pwr     (pwr),
        .ch_id   (3'(g)),
        .step    (step[g]),
        .clr_vec (clr_vec[g]),
        .src_q   (src[g]),
        .dst_q   (dst[g]),
        .cnt_q   (cnt[g]),
        .mode_q  (mode[g]),
        .vec_q   (vec[g])
      );
    end
  endgenerate

  // Source k (1..33) maps to start vector k; vector 0 means disarmed
  always_comb begin
    owned  = '0;
    ch_req = '0;
    for (int c = 0; c < umd_pkg::NUM_CH; c++) begin
      for (int k = 0; k < 33; k++) begin
        if (vec[c] != umd_pkg::VEC_NONE && vec[c] == 8'(k + 1)) begin
          owned[k] = 1'b1;
          if (int_pend[k]) begin
            ch_req[c] = 1'b1;
          end
        end
      end
      if (sw_req_q[c]) begin
        ch_req[c] = 1'b1;
      end
    end
  end

  // Fixed priority by channel number
  always_comb begin
    win = 3'h0;
    for (int c = umd_pkg::NUM_CH - 1; c >= 0; c--) begin
      if (ch_req[c]) begin
        win = 3'(c);
      end
    end
  end

  assign any_req = |ch_req;
  assign end_hit = (state_q == umd_pkg::UMD_DONE) && (cnt[act_q] == 16'h0000);

  always_comb begin
    state_d = state_q;
    case (state_q)
      umd_pkg::UMD_IDLE: begin
        if (dma_ack && any_req && !cpu_halted) begin
          state_d = umd_pkg::UMD_FETCH;
        end
      end
      umd_pkg::UMD_FETCH: state_d = umd_pkg::UMD_READ;
      umd_pkg::UMD_READ:  state_d = umd_pkg::UMD_WRITE;
      umd_pkg::UMD_WRITE: state_d = umd_pkg::UMD_TAIL;
      umd_pkg::UMD_TAIL:  state_d = umd_pkg::UMD_DONE;
      umd_pkg::UMD_DONE: begin
        if (burst_q[act_q] && cnt[act_q] != 16'h0000 && !cpu_halted) begin
          state_d = umd_pkg::UMD_FETCH;
        end else begin
          state_d = umd_pkg::UMD_IDLE;
        end
      end
      default: state_d = umd_pkg::UMD_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= umd_pkg::UMD_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      act_q    <= 3'h0;
      act_sw_q <= 1'b0;
    end else if (state_q == umd_pkg::UMD_IDLE && state_d == umd_pkg::UMD_FETCH) begin
      act_q    <= win;
      act_sw_q <= sw_req_q[win];
    end
  end

  // Counter and addresses step once, in the tail state after the write
  always_comb begin
    step    = '0;
    clr_vec = '0;
    if (state_q == umd_pkg::UMD_TAIL) begin
      step[act_q] = 1'b1;
    end
    if (end_hit) begin
      clr_vec[act_q] = 1'b1;
    end
  end

  // Soft start into a running interrupt transfer is dropped, so it never steps the counter
  always_comb begin
    sw_keep = 8'hff;
    if (state_q != umd_pkg::UMD_IDLE && !act_sw_q) begin
      sw_keep[act_q] = 1'b0;
    end
  end

  // Write data is taken straight from the read cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_q <= '0;
    end else begin
      bus_q <= '0;
      if (state_d == umd_pkg::UMD_READ && mode[act_q][4:2] != umd_pkg::MODE_COUNTER) begin
        bus_q.valid <= 1'b1;
        bus_q.addr  <= src[act_q];
        bus_q.size  <= mode[act_q][1:0];
      end else if (state_d == umd_pkg::UMD_WRITE && mode[act_q][4:2] != umd_pkg::MODE_COUNTER) begin
        bus_q.valid <= 1'b1;
        bus_q.write <= 1'b1;
        bus_q.addr  <= dst[act_q];
        bus_q.size  <= mode[act_q][1:0];
        bus_q.wdata <= mem_rdata;
      end
    end
  end

  // Request to CPU always at level six
  always_ff @(posedge clk) begin
    if (rst) begin
      dma_req   <= 1'b0;
      dma_level <= 3'h0;
    end else begin
      dma_req   <= any_req && state_q == umd_pkg::UMD_IDLE;
      dma_level <= umd_pkg::DMA_LEVEL;
    end
  end

  // Clear the source flag on acceptance of an interrupt started request
  always_ff @(posedge clk) begin
    if (rst) begin
      int_clr <= '0;
    end else begin
      int_clr <= '0;
      if (state_q == umd_pkg::UMD_IDLE && state_d == umd_pkg::UMD_FETCH && !sw_req_q[win]) begin
        for (int k = 0; k < 33; k++) begin
          if (vec[win] == 8'(k + 1)) begin
            int_clr[k] <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dma_owned <= '0;
    end else begin
      dma_owned <= owned;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tc_irq <= '0;
    end else begin
      tc_irq <= '0;
      if (end_hit) begin
        tc_irq[act_q] <= 1'b1;
      end
    end
  end

  assign sw_set = (reg_wr && reg_addr == umd_pkg::SW_REQ_OFFSET) ? (reg_wdata & sw_keep) : 8'h00;

  // New set wins over completion clear
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_req_q <= umd_pkg::SW_REQ_RESET;
    end else begin
      for (int c = 0; c < umd_pkg::NUM_CH; c++) begin
        if (sw_set[c]) begin
          sw_req_q[c] <= 1'b1;
        end else if (state_q == umd_pkg::UMD_DONE && act_sw_q && act_q == 3'(c)) begin
          sw_req_q[c] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      burst_q <= umd_pkg::BURST_SEL_RESET;
    end else if (reg_wr && reg_addr == umd_pkg::BURST_SEL_OFFSET) begin
      burst_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && reg_addr == umd_pkg::SW_REQ_OFFSET) begin
      reg_rdata <= sw_req_q;
    end else if (reg_rd && reg_addr == umd_pkg::BURST_SEL_OFFSET) begin
      reg_rdata <= burst_q;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_out <= 6'h01;
    end else begin
      state_out <= state_d;
    end
  end

endmodule // umd_engine

// [umd_engine_asserts.sv]
// Purpose: Port checker for umd_engine
// Assumes: Bound from the bench top
// Notes:   Cycle figures follow the transfer walk
`timescale 1ns/10ps
module umd_engine_asserts (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  cpu_halted,
  input wire logic                  reg_rd,
  input wire logic [31:0]           mem_rdata,
  input wire logic [7:0]            reg_rdata,
  input wire logic [2:0]            dma_level,
  input wire logic [32:0]           int_clr,
  input wire logic [7:0]            tc_irq,
  input wire umd_pkg::umd_bus_req_t bus_q,
  input wire logic [5:0]            state_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  level_six_a: assert property (!$past(rst) |-> dma_level == 3'h6) else $error("level not six");
  halt_hold_a: assert property (cpu_halted && state_out == 6'h01 |=> state_out == 6'h01 && int_clr == 33'h0)
    else $error("service while halted");
  clr_pulse_a: assert property (int_clr != 33'h0 |-> $onehot(int_clr) && state_out == 6'h02 ##1 int_clr == 33'h0)
    else $error("bad flag clear pulse");
  read_write_a: assert property (bus_q.valid && !bus_q.write |=> bus_q.valid && bus_q.write
    && bus_q.wdata == $past(mem_rdata)) else $error("write does not follow read");
  end_pulse_a: assert property (tc_irq != 8'h0 |-> $onehot(tc_irq) && $past(state_out) == 6'h20 ##1 tc_irq == 8'h0)
    else $error("bad end pulse");
  state_hot_a: assert property (!$past(rst) |-> $onehot(state_out)) else $error("state not one hot");
  bus_state_a: assert property (bus_q.valid |-> state_out == (bus_q.write ? 6'h08 : 6'h04))
    else $error("bus cycle in wrong state");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data without read");
  cover property (tc_irq != 8'h0);
  cover property (int_clr != 33'h0);
  cover property (bus_q.valid && bus_q.write);
endmodule // umd_engine_asserts

// [umd_pkg.sv]
// Purpose: Shared constants and types for the interrupt driven micro DMA engine
// Assumes: Single 200 MHz clock, synchronous active high reset
// Notes:   Register offsets, mode codes, reset values and state encodings
package umd_pkg;

  localparam int unsigned NUM_CH     = 8;
  localparam int unsigned NUM_SRC    = 34;
  localparam int unsigned VEC_W      = 8;
  localparam int unsigned ADDR_W     = 24;
  localparam int unsigned CNT_W      = 16;

  localparam logic [8:0]  SW_REQ_OFFSET    = 9'h109;
  localparam logic [8:0]  BURST_SEL_OFFSET = 9'h10a;
  localparam logic [7:0]  SW_REQ_RESET     = 8'h00;
  localparam logic [7:0]  BURST_SEL_RESET  = 8'h00;

  localparam logic [2:0]  DMA_LEVEL        = 3'h6;
  localparam logic [7:0]  VEC_NONE         = 8'h00;

  localparam logic [1:0]  SIZE_1           = 2'h0;
  localparam logic [1:0]  SIZE_2           = 2'h1;
  localparam logic [1:0]  SIZE_4           = 2'h2;

  localparam logic [2:0]  MODE_DST_INC     = 3'h0;
  localparam logic [2:0]  MODE_DST_DEC     = 3'h1;
  localparam logic [2:0]  MODE_SRC_INC     = 3'h2;
  localparam logic [2:0]  MODE_SRC_DEC     = 3'h3;
  localparam logic [2:0]  MODE_BOTH_INC    = 3'h4;
  localparam logic [2:0]  MODE_BOTH_DEC    = 3'h5;
  localparam logic [2:0]  MODE_FIXED       = 3'h6;
  localparam logic [2:0]  MODE_COUNTER     = 3'h7;

  localparam logic [2:0]  PARAM_SRC        = 3'h0;
  localparam logic [2:0]  PARAM_DST        = 3'h1;
  localparam logic [2:0]  PARAM_CNT        = 3'h2;
  localparam logic [2:0]  PARAM_MODE       = 3'h3;
  localparam logic [2:0]  PARAM_VEC        = 3'h4;

  typedef enum logic [5:0] {
    UMD_IDLE  = 6'b000001,
    UMD_FETCH = 6'b000010,
    UMD_READ  = 6'b000100,
    UMD_WRITE = 6'b001000,
    UMD_TAIL  = 6'b010000,
    UMD_DONE  = 6'b100000
  } umd_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [23:0] addr;
    logic [1:0]  size;
    logic [31:0] wdata;
  } umd_bus_req_t;

  typedef struct packed {
    logic        wr;
    logic [2:0]  ch;
    logic [2:0]  sel;
    logic [31:0] data;
  } umd_param_wr_t;

endpackage
